/* design/cmrc_pkg.sv */
`default_nettype none

package cmrc_pkg;

    // ************************************************************
    // Widths and message RAM layout
    // ************************************************************
    localparam int unsigned DATA_W    = 32;
    localparam int unsigned CHK_W     = 7;
    localparam int unsigned WORD_W    = DATA_W + CHK_W;
    localparam int unsigned HAM_BITS  = 6;
    localparam int unsigned NUM_CAN   = 2;
    localparam int unsigned CAN_WORDS = 1216;
    localparam int unsigned RAM_WORDS = NUM_CAN * CAN_WORDS;
    localparam int unsigned CAN_AW    = 11;
    localparam int unsigned RAM_AW    = 12;

    localparam logic [RAM_AW-1:0] CAN0_BASE = 12'h000;
    localparam logic [RAM_AW-1:0] CAN1_BASE = RAM_AW'(CAN_WORDS);

    // ************************************************************
    // CPU access size codes
    // ************************************************************
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;

    typedef enum logic [1:0] {
        CMRC_OWN_NONE,
        CMRC_OWN_CPU,
        CMRC_OWN_CAN0,
        CMRC_OWN_CAN1
    } cmrc_own_t;

    typedef logic [WORD_W-1:0] cmrc_word_t;

    // ************************************************************
    // SECDED helpers: bit 0 is overall parity, powers of two are checks
    // ************************************************************
    function automatic logic cmrc_is_chk(input int pos);
        return (pos == 0) || ((pos & (pos - 1)) == 0);
    endfunction

    function automatic logic cmrc_par_sel(input cmrc_word_t w, input int b);
        logic p;
        p = 1'b0;
        for (int pos = 1; pos < WORD_W; pos++)
        begin
            if (((pos >> b) & 1) == 1)
                p = p ^ w[pos];
        end
        return p;
    endfunction

    function automatic cmrc_word_t cmrc_encode(input logic [DATA_W-1:0] d);
        cmrc_word_t w;
        int         k;
        w = '0;
        k = 0;
        for (int pos = 1; pos < WORD_W; pos++)
        begin
            if (!cmrc_is_chk(pos))
            begin
                w[pos] = d[k];
                k++;
            end
        end
        for (int b = 0; b < HAM_BITS; b++)
            w[1 << b] = cmrc_par_sel(w, b);
        w[0] = ^w;
        return w;
    endfunction

    function automatic logic [DATA_W-1:0] cmrc_extract(input cmrc_word_t w);
        logic [DATA_W-1:0] d;
        int                k;
        d = '0;
        k = 0;
        for (int pos = 1; pos < WORD_W; pos++)
        begin
            if (!cmrc_is_chk(pos))
            begin
                d[k] = w[pos];
                k++;
            end
        end
        return d;
    endfunction

    function automatic logic [CHK_W-1:0] cmrc_chk(input cmrc_word_t w);
        logic [CHK_W-1:0] c;
        c[0] = w[0];
        for (int b = 0; b < HAM_BITS; b++)
            c[b + 1] = w[1 << b];
        return c;
    endfunction

    // Upper bit is overall parity, lower bits the Hamming position
    function automatic logic [CHK_W-1:0] cmrc_syndrome(input cmrc_word_t w);
        logic [CHK_W-1:0] s;
        for (int b = 0; b < HAM_BITS; b++)
            s[b] = cmrc_par_sel(w, b);
        s[CHK_W-1] = ^w;
        return s;
    endfunction

endpackage

`default_nettype wire

/* design/cmrc_arb_if.sv */
`timescale 1ns/10ps
`default_nettype none

interface cmrc_arb_if;
    import cmrc_pkg::*;

    logic               cpu_req;
    logic [NUM_CAN-1:0] can_req;
    logic               cpu_gnt;
    logic [NUM_CAN-1:0] can_gnt;

    modport arb  (input cpu_req, input can_req, output cpu_gnt, output can_gnt);
    modport user (output cpu_req, output can_req, input cpu_gnt, input can_gnt);
endinterface

`default_nettype wire

/* design/cmrc_ecc_chk.sv */
`timescale 1ns/10ps
`default_nettype none

module cmrc_ecc_chk
    import cmrc_pkg::*;
(
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_chk_en,
    input  wire logic [WORD_W-1:0]     i_word,
    output logic      [DATA_W-1:0]     o_data,
    output logic                       o_fix,
    output logic                       o_bad
);
    logic [CHK_W-1:0] syn;
    logic [5:0]       pos;
    logic             par;
    logic             solid;
    cmrc_word_t       fixed;

    // ************************************************************
    // Syndrome decode and single-bit repair
    // ************************************************************
    always_comb
    begin
        syn   = cmrc_syndrome(i_word);
        pos   = syn[HAM_BITS-1:0];
        par   = syn[CHK_W-1];
        solid = (i_word == '0) || (i_word == '1);                               // [R11]
        fixed = i_word;
        o_fix = 1'b0;
        o_bad = 1'b0;
        if (solid || (!par && pos != '0) || (par && 32'(pos) >= WORD_W))        // [R9]
            o_bad = 1'b1;
        else if (par)
        begin
            fixed[pos] = ~fixed[pos];                                           // [R9]
            o_fix      = 1'b1;
        end
        o_data = cmrc_extract(fixed);                                           // [R12]
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    a_single_repair: assert property (i_chk_en && $countones(i_word ^ cmrc_encode(o_data)) == 1
        && i_word != '1 |-> o_fix && !o_bad) else $error("single flip not repaired"); // [R9]
    a_solid_word: assert property (i_chk_en && (i_word == '0 || i_word == '1) |-> o_bad && !o_fix)
        else $error("solid word not flagged"); // [R11]
endmodule

`default_nettype wire

/* design/cmrc_arb.sv */
`timescale 1ns/10ps
`default_nettype none

module cmrc_arb
    import cmrc_pkg::*;
(
    input  wire logic  i_ref_clk,
    input  wire logic  i_rst_n,
    cmrc_arb_if.arb    arb
);
    logic               last_cpu_q, last_cpu_d;
    logic               rr_q, rr_d;
    logic [NUM_CAN-1:0] seen_q, seen_d;
    logic [NUM_CAN-1:0] can_ok;
    logic               can_pick;

    // ************************************************************
    // Grant decision
    // ************************************************************
    always_comb
    begin
        can_ok      = arb.can_req & seen_q;                                     // [R3]
        can_pick    = (can_ok == 2'h3) ? rr_q : can_ok[1];                      // [R1] [R6]
        arb.cpu_gnt = 1'b0;
        arb.can_gnt = '0;
        if (|can_ok && (last_cpu_q || !arb.cpu_req))                            // [R2] [R4]
            arb.can_gnt[can_pick] = 1'b1;
        else if (arb.cpu_req)
            arb.cpu_gnt = 1'b1;                                                 // [R5]
        seen_d     = arb.can_req;
        last_cpu_d = arb.cpu_gnt ? 1'b1 : (|arb.can_gnt ? 1'b0 : last_cpu_q);
        rr_d       = arb.can_gnt[0] ? 1'b1 : (arb.can_gnt[1] ? 1'b0 : rr_q);    // [R1]
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            last_cpu_q <= 1'b0;                                                 // [R19]
            rr_q       <= 1'b0;
            seen_q     <= '0;
        end
        else
        begin
            last_cpu_q <= last_cpu_d;
            rr_q       <= rr_d;
            seen_q     <= seen_d;
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_cpu_waits;
        arb.cpu_req && !arb.cpu_gnt ##1 arb.cpu_req;
    endsequence

    a_cpu_wait_max: assert property (s_cpu_waits |-> arb.cpu_gnt)
        else $error("cpu waited over one cycle"); // [R2]
    a_can_fresh_wait: assert property ($rose(arb.can_req[0]) || $rose(arb.can_req[1])
        |-> (arb.can_gnt & (arb.can_req & ~$past(arb.can_req))) == '0)
        else $error("fresh can request granted at once"); // [R3]
    a_cpu_alone: assert property (arb.cpu_req && (arb.can_req & seen_q) == '0 |-> arb.cpu_gnt)
        else $error("cpu alone not granted"); // [R5]
    a_can_alone: assert property (!arb.cpu_req && |(arb.can_req & seen_q) |-> |arb.can_gnt)
        else $error("idle cpu left can waiting"); // [R4]
    a_rr_turn: assert property (arb.can_gnt[0] ##1 (&(arb.can_req & seen_q)) && !arb.cpu_gnt
        |-> arb.can_gnt[1]) else $error("round robin skipped can1"); // [R1] [R6]
    a_grant_onehot: assert property ($onehot0({arb.cpu_gnt, arb.can_gnt})
        && (!arb.cpu_gnt || arb.cpu_req)) else $error("bad grant vector"); // [R1]
endmodule

`default_nettype wire

/* design/cmrc_top.sv */
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// [R1] Round-robin grant between the two cans, alternating with cpu
// [R2] Cpu gets half, waits one cycle most
// [R3] Cans share half, fresh request waits one
// [R4] Idle cpu: cans take whole bandwidth
// [R5] Idle cans: cpu takes whole bandwidth
// [R6] Lone can takes idle can's share
// [R7] Address cycle, then data cycle
// [R8] Data phase overlaps next address phase
// [R9] Correct single errors, flag double errors
// [R10] Store 32 data plus 7 check bits
// [R11] All-zero or all-one word is uncorrectable
// [R12] Encode on write, check and correct read
// [R13] Forward check bits to the can
// [R14] Ram port issues only full words
// [R15] Cpu reads byte, half or word
// [R16] Never report a transfer error
// [R17] Each can owns a 1216-word region
// [R18] Narrow read returns corrected addressed lanes
// [R19] Reset: fixed pointer, no grant
module cmrc_top
    import cmrc_pkg::*;
(
    input  wire logic                                  i_ref_clk,
    input  wire logic                                  i_rst_n,
    input  wire logic                                  i_cpu_req,
    input  wire logic                                  i_cpu_we,
    input  wire logic [cmrc_pkg::RAM_AW-1:0]           i_cpu_addr,
    input  wire logic [1:0]                            i_cpu_size,
    input  wire logic [1:0]                            i_cpu_off,
    input  wire logic [cmrc_pkg::DATA_W-1:0]           i_cpu_wdata,
    output logic                                       o_cpu_gnt,
    output logic                                       o_cpu_done,
    output logic      [cmrc_pkg::DATA_W-1:0]           o_cpu_rdata,
    output logic                                       o_cpu_ecc_fix,
    output logic                                       o_cpu_ecc_bad,
    output logic                                       o_cpu_err,
    input  wire logic [1:0]                            i_can_req,
    input  wire logic [1:0]                            i_can_we,
    input  wire logic [1:0][cmrc_pkg::CAN_AW-1:0]      i_can_addr,
    input  wire logic [1:0][cmrc_pkg::DATA_W-1:0]      i_can_wdata,
    output logic      [1:0]                            o_can_gnt,
    output logic      [1:0]                            o_can_done,
    output logic      [1:0][cmrc_pkg::DATA_W-1:0]      o_can_rdata,
    output logic      [1:0][cmrc_pkg::CHK_W-1:0]       o_can_chk,
    output logic      [1:0]                            o_can_ecc_fix,
    output logic      [1:0]                            o_can_ecc_bad,
    output logic      [1:0]                            o_can_err,
    output logic                                       o_ram_cs,
    output logic                                       o_ram_we,
    output logic      [cmrc_pkg::RAM_AW-1:0]           o_ram_addr,
    output logic      [cmrc_pkg::WORD_W-1:0]           o_ram_wdata,
    input  wire logic [cmrc_pkg::WORD_W-1:0]           i_ram_rdata
);
    import cmrc_pkg::*;

    // ************************************************************
    // Pipeline state
    // ************************************************************
    logic              a_vld_q,  a_vld_d;
    logic              a_we_q,   a_we_d;
    cmrc_own_t         a_own_q,  a_own_d;
    logic [RAM_AW-1:0] a_addr_q, a_addr_d;
    cmrc_word_t        a_word_q, a_word_d;
    logic [1:0]        a_size_q, a_size_d;
    logic [1:0]        a_off_q,  a_off_d;

    logic              d_vld_q,  d_vld_d;
    logic              d_we_q,   d_we_d;
    cmrc_own_t         d_own_q,  d_own_d;
    cmrc_word_t        d_word_q, d_word_d;
    logic [1:0]        d_size_q, d_size_d;
    logic [1:0]        d_off_q,  d_off_d;

    logic              r_vld_q,  r_vld_d;
    cmrc_own_t         r_own_q,  r_own_d;
    logic [DATA_W-1:0] r_data_q, r_data_d;
    logic [CHK_W-1:0]  r_chk_q,  r_chk_d;
    logic              r_fix_q,  r_fix_d;
    logic              r_bad_q,  r_bad_d;

    logic [DATA_W-1:0] dec_data;
    logic              dec_fix;
    logic              dec_bad;
    logic              any_gnt;

    cmrc_arb_if arb_bus ();

    // ************************************************************
    // Arbiter and read checker
    // ************************************************************
    assign arb_bus.cpu_req = i_cpu_req;
    assign arb_bus.can_req = i_can_req;
    assign o_cpu_gnt       = arb_bus.cpu_gnt;
    assign o_can_gnt       = arb_bus.can_gnt;
    assign any_gnt         = arb_bus.cpu_gnt || (|arb_bus.can_gnt);

    cmrc_arb u_arb (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .arb       (arb_bus.arb)
    );

    cmrc_ecc_chk u_ecc_chk (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_chk_en  (d_vld_q && !d_we_q),
        .i_word    (i_ram_rdata),
        .o_data    (dec_data),
        .o_fix     (dec_fix),
        .o_bad     (dec_bad)
    );

    // Narrow reads still fetch and repair the whole word, then pick lanes
    function automatic logic [DATA_W-1:0] lane_pick(input logic [DATA_W-1:0] w,
                                                    input logic [1:0]        size,
                                                    input logic [1:0]        off);
        logic [DATA_W-1:0] sh;
        sh = w >> (8 * off);
        if (size == SIZE_BYTE)
            return {24'h000000, sh[7:0]};
        else if (size == SIZE_HALF)
            return {16'h0000, (off[1] ? w[31:16] : w[15:0])};
        else
            return w;
    endfunction

    // ************************************************************
    // Address phase capture
    // ************************************************************
    always_comb
    begin
        a_vld_d  = any_gnt;
        a_we_d   = 1'b0;
        a_own_d  = CMRC_OWN_NONE;
        a_addr_d = a_addr_q;
        a_word_d = '0;
        a_size_d = SIZE_WORD;
        a_off_d  = 2'h0;
        if (arb_bus.cpu_gnt)
        begin
            a_own_d  = CMRC_OWN_CPU;
            a_we_d   = i_cpu_we;
            a_addr_d = i_cpu_addr;
            a_word_d = cmrc_encode(i_cpu_wdata);                                // [R12]
            a_size_d = i_cpu_we ? SIZE_WORD : i_cpu_size;                       // [R15]
            a_off_d  = i_cpu_we ? 2'h0 : i_cpu_off;
        end
        else if (arb_bus.can_gnt[0])
        begin
            a_own_d  = CMRC_OWN_CAN0;
            a_we_d   = i_can_we[0];
            a_addr_d = CAN0_BASE + RAM_AW'(i_can_addr[0]);                      // [R17]
            a_word_d = cmrc_encode(i_can_wdata[0]);                             // [R10]
        end
        else if (arb_bus.can_gnt[1])
        begin
            a_own_d  = CMRC_OWN_CAN1;
            a_we_d   = i_can_we[1];
            a_addr_d = CAN1_BASE + RAM_AW'(i_can_addr[1]);                      // [R17]
            a_word_d = cmrc_encode(i_can_wdata[1]);                             // [R10]
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            a_vld_q  <= 1'b0;
            a_we_q   <= 1'b0;
            a_own_q  <= CMRC_OWN_NONE;
            a_addr_q <= '0;
            a_word_q <= '0;
            a_size_q <= SIZE_WORD;
            a_off_q  <= 2'h0;
        end
        else
        begin
            a_vld_q  <= a_vld_d;                                                // [R7]
            a_we_q   <= a_we_d;
            a_own_q  <= a_own_d;
            a_addr_q <= a_addr_d;
            a_word_q <= a_word_d;
            a_size_q <= a_size_d;
            a_off_q  <= a_off_d;
        end
    end

    // ************************************************************
    // Data phase and response
    // ************************************************************
    // The data stage runs beside the next address stage; no bubble between
    always_comb
    begin
        d_vld_d  = a_vld_q;                                                     // [R8]
        d_we_d   = a_vld_q && a_we_q;
        d_own_d  = a_own_q;
        d_word_d = (a_vld_q && a_we_q) ? a_word_q : '0;
        d_size_d = a_size_q;
        d_off_d  = a_off_q;

        r_vld_d  = d_vld_q;
        r_own_d  = d_own_q;
        r_data_d = '0;
        r_chk_d  = cmrc_chk(d_word_q);                                          // [R13]
        r_fix_d  = 1'b0;
        r_bad_d  = 1'b0;
        if (d_vld_q && !d_we_q)
        begin
            r_chk_d = cmrc_chk(cmrc_encode(dec_data));                          // [R13]
            r_fix_d = dec_fix;                                                  // [R9]
            r_bad_d = dec_bad;
            case (d_own_q)
                CMRC_OWN_CPU:  r_data_d = lane_pick(dec_data, d_size_q, d_off_q); // [R18]
                CMRC_OWN_CAN0: r_data_d = dec_data;
                CMRC_OWN_CAN1: r_data_d = dec_data;
                default:       r_data_d = '0;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            d_vld_q  <= 1'b0;
            d_we_q   <= 1'b0;
            d_own_q  <= CMRC_OWN_NONE;
            d_word_q <= '0;
            d_size_q <= SIZE_WORD;
            d_off_q  <= 2'h0;
            r_vld_q  <= 1'b0;
            r_own_q  <= CMRC_OWN_NONE;
            r_data_q <= '0;
            r_chk_q  <= '0;
            r_fix_q  <= 1'b0;
            r_bad_q  <= 1'b0;
        end
        else
        begin
            d_vld_q  <= d_vld_d;
            d_we_q   <= d_we_d;
            d_own_q  <= d_own_d;
            d_word_q <= d_word_d;
            d_size_q <= d_size_d;
            d_off_q  <= d_off_d;
            r_vld_q  <= r_vld_d;
            r_own_q  <= r_own_d;
            r_data_q <= r_data_d;
            r_chk_q  <= r_chk_d;
            r_fix_q  <= r_fix_d;
            r_bad_q  <= r_bad_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Only whole 39-bit words reach the RAM; there are no lane strobes
    assign o_ram_cs    = a_vld_q;                                               // [R7]
    assign o_ram_we    = a_vld_q && a_we_q;                                     // [R14]
    assign o_ram_addr  = a_addr_q;
    assign o_ram_wdata = d_word_q;                                              // [R14]

    assign o_cpu_done    = r_vld_q && (r_own_q == CMRC_OWN_CPU);
    assign o_cpu_rdata   = r_data_q;
    assign o_cpu_ecc_fix = o_cpu_done && r_fix_q;
    assign o_cpu_ecc_bad = o_cpu_done && r_bad_q;
    assign o_cpu_err     = 1'b0;                                                // [R16]

    always_comb
    begin
        o_can_done[0] = r_vld_q && (r_own_q == CMRC_OWN_CAN0);
        o_can_done[1] = r_vld_q && (r_own_q == CMRC_OWN_CAN1);
        for (int i = 0; i < NUM_CAN; i++)
        begin
            o_can_rdata[i]   = r_data_q;
            o_can_chk[i]     = r_chk_q;                                         // [R13]
            o_can_ecc_fix[i] = o_can_done[i] && r_fix_q;
            o_can_ecc_bad[i] = o_can_done[i] && r_bad_q;
            o_can_err[i]     = 1'b0;                                            // [R16]
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_cpu_read;
        o_cpu_gnt && !i_cpu_we;
    endsequence

    sequence s_can0_write;
        o_can_gnt[0] && i_can_we[0];
    endsequence

    a_addr_phase: assert property (o_cpu_gnt |=> o_ram_cs && o_ram_addr == $past(i_cpu_addr))
        else $error("cpu address not presented next cycle"); // [R7]
    a_pipe_overlap: assert property (any_gnt ##1 any_gnt |=> o_ram_cs && d_vld_q)
        else $error("back to back access not overlapped"); // [R8]
    a_cpu_read_rsp: assert property (s_cpu_read |-> ##3 o_cpu_done)
        else $error("cpu read answer not on third cycle"); // [R7] [R12]
    a_write_word: assert property (s_can0_write |-> ##2
        o_ram_wdata == cmrc_encode($past(i_can_wdata[0], 2)))
        else $error("written word has wrong check bits"); // [R10] [R12] [R14]
    a_chk_forward: assert property (s_can0_write |-> ##3 o_can_done[0]
        && o_can_chk[0] == cmrc_chk(cmrc_encode($past(i_can_wdata[0], 3))))
        else $error("check bits not forwarded to can"); // [R13]
    a_can_region: assert property (o_can_gnt[1] |=> o_ram_addr >= CAN1_BASE
        && o_ram_addr < RAM_AW'(RAM_WORDS)) else $error("can1 outside its region"); // [R17]
    a_byte_read: assert property ((s_cpu_read and i_cpu_size == SIZE_BYTE) |-> ##3
        o_cpu_rdata[31:8] == '0) else $error("byte read leaks upper lanes"); // [R15] [R18]
    a_reset_idle: assert property (!i_cpu_req && i_can_req == 2'h0 |-> !any_gnt ##1 !o_ram_cs)
        else $error("grant or access without request"); // [R19]
endmodule

`default_nettype wire

/* dv/cmrc_ram_model.sv */
`timescale 1ns/10ps
`default_nettype none
module cmrc_ram_model
    import cmrc_pkg::*;
(
    input  wire logic                           i_ref_clk,
    input  wire logic                           i_cs,
    input  wire logic                           i_we,
    input  wire logic [cmrc_pkg::RAM_AW-1:0]    i_addr,
    input  wire logic [cmrc_pkg::WORD_W-1:0]    i_wdata,
    output logic      [cmrc_pkg::WORD_W-1:0]    o_rdata
);
    logic [WORD_W-1:0] mem [RAM_WORDS];
    logic              wr_q = 1'b0;
    logic [RAM_AW-1:0] wa_q = '0;
    initial o_rdata = '0;
    // Synchronous part: data phase follows the address phase
    always @(posedge i_ref_clk)
    begin
        wr_q <= i_cs && i_we;
        wa_q <= i_addr;
        if (wr_q)
            mem[wa_q] <= i_wdata; // whole words only
        if (i_cs && !i_we)
            o_rdata <= (wr_q && wa_q == i_addr) ? i_wdata : mem[i_addr];
        else
            o_rdata <= ~o_rdata; // No stale copy outside the read slot
    end
endmodule
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import cmrc_pkg::*;
    logic clk = 0, rst_n = 0, cpu_req = 0, cpu_we = 0;
    logic cpu_gnt, cpu_done, c_fix, c_bad, ram_cs, ram_we;
    logic [1:0] sz_q = 0, off_q = 0, can_req = 0, can_we = 0, can_gnt, can_done, n_fix, n_bad;
    logic [1:0] fb, cpu_err_v, can_err;
    logic [RAM_AW-1:0] cpu_addr = 0, ram_addr;
    logic [DATA_W-1:0] cpu_wdata = 0, cpu_rdata, q, d;
    logic [1:0][CAN_AW-1:0] can_addr = '0;
    logic [1:0][DATA_W-1:0] can_wdata = '0, can_rdata;
    logic [1:0][CHK_W-1:0] can_chk;
    logic [WORD_W-1:0] ram_wdata, ram_rdata, m;
    logic [CHK_W-1:0] ck;
    logic [2:0] mk;
    int miscompares = 0, n_compared = 0, a, p, e, g[3];
    always #4 clk = ~clk;
    cmrc_top u_cmrc_top (.i_ref_clk(clk), .i_rst_n(rst_n), .i_cpu_req(cpu_req), .i_cpu_we(cpu_we),
        .i_cpu_addr(cpu_addr), .i_cpu_size(sz_q), .i_cpu_off(off_q), .i_cpu_wdata(cpu_wdata),
        .o_cpu_gnt(cpu_gnt), .o_cpu_done(cpu_done), .o_cpu_rdata(cpu_rdata), .o_cpu_ecc_fix(c_fix),
        .o_cpu_ecc_bad(c_bad), .o_cpu_err(cpu_err_v[0]), .i_can_req(can_req), .i_can_we(can_we),
        .i_can_addr(can_addr), .i_can_wdata(can_wdata), .o_can_gnt(can_gnt), .o_can_done(can_done),
        .o_can_rdata(can_rdata), .o_can_chk(can_chk), .o_can_ecc_fix(n_fix), .o_can_ecc_bad(n_bad),
        .o_can_err(can_err), .o_ram_cs(ram_cs), .o_ram_we(ram_we), .o_ram_addr(ram_addr),
        .o_ram_wdata(ram_wdata), .i_ram_rdata(ram_rdata));
    cmrc_ram_model u_cmrc_ram_model (.i_ref_clk(clk), .i_cs(ram_cs), .i_we(ram_we),
        .i_addr(ram_addr), .i_wdata(ram_wdata), .o_rdata(ram_rdata));
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // One access: hold the request until the grant edge, answer three cycles later
    task automatic acc(input int w, input logic we, input int ad, input logic [31:0] dt,
                       input int sz, input int of);
        int n = 0;
        @(posedge clk);
        if (w == 0)
            {cpu_req, cpu_we, cpu_addr, cpu_wdata, sz_q, off_q}
                <= {1'b1, we, 12'(ad), dt, 2'(sz), 2'(of)};
        else
            {can_req[w-1], can_we[w-1], can_addr[w-1], can_wdata[w-1]} <= {1'b1, we, 11'(ad), dt};
        do @(posedge clk); while (!(w == 0 ? cpu_gnt : can_gnt[w-1]) && ++n < 20);
        cpu_req <= 1'b0;
        can_req <= 2'h0;
        if (n >= 20)
        begin
            miscompares++;
            results();
        end
        repeat (3) @(posedge clk);
        q = w == 0 ? cpu_rdata : can_rdata[w==2];
        fb = w == 0 ? {c_fix, c_bad} : {n_fix[w==2], n_bad[w==2]};
        ck = can_chk[w==2];
        chk({w == 0 ? cpu_done : can_done[w==2], cpu_err_v[0], can_err}, 4'h8);
    endtask
    initial
    begin
        void'($urandom(18819));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 9; i++)
        begin
            p = i % 3;
            a = p == 0 ? $urandom % 2432 : $urandom % 1216;
            d = $urandom;
            acc(p, 1, a, d, 2, 0);
            acc(p, 0, a, d, 2, 0);
            chk({fb, q}, {2'h0, d});
            if (p > 0)
            begin
                m = u_cmrc_ram_model.mem[a + 1216 * (p - 1)];
                chk(ck, {m[32], m[16], m[8], m[4], m[2], m[1], m[0]});
                acc(0, 0, a + 1216 * (p - 1), 0, 2, 0);
                chk(q, d);
            end
        end
        for (int i = 0; i < 8; i++)
        begin
            acc(0, 0, a + 1216, 0, i / 4, i % 4);
            chk(q, i < 4 ? (d >> 8 * (i % 4)) & 32'hFF
                : (d >> 16 * (i / 2 % 2)) & 32'hFFFF);
        end
        $display("test word and narrow access done");
        for (int k = 0; k < 4; k++)
        begin
            p = $urandom % 38;
            acc(0, 1, a, d, 2, 0);
            m = u_cmrc_ram_model.mem[a];
            u_cmrc_ram_model.mem[a] = k == 0 ? m ^ (39'h1 << p) : k == 1 ? m ^ (39'h3 << p) : {39{k[0]}};
            acc(0, 0, a, 0, 2, 0);
            chk(fb, k == 0 ? 2'h2 : 2'h1);
            if (k == 0)
                chk(q, d);
        end
        $display("test ecc done");
        for (int k = 0; k < 4; k++)
        begin
            mk = 3'(12'h7F1 >> (3 * k));
            g = '{0, 0, 0};
            @(posedge clk);
            {can_req, cpu_req, cpu_we, can_we} <= {mk, 3'h0};
            for (int c = 0; c < 12; c++)
            begin
                @(posedge clk);
                if (c == 0)
                    chk(can_gnt, 0);
                chk($countones({can_gnt, cpu_gnt}) > 1, 0);
                g[0] += cpu_gnt;
                g[1] += can_gnt[0];
                g[2] += can_gnt[1];
            end
            {can_req, cpu_req} <= 3'h0;
            repeat (4) @(posedge clk);
            e = mk[2:1] == 0 ? 0 : mk[0] ? 6 : 11;
            chk(g[0], mk[0] ? 12 - e : 0);
            chk(g[1] + g[2], e);
            chk({mk[1] || g[1] == 0, mk[2] || g[2] == 0,
                !(&mk[2:1]) || g[1] - g[2] + 1 inside {[0:2]}}, 3'h7);
        end
        $display("test arbitration done");
        results();
    end
endmodule
`default_nettype wire
